// [logic/tcb_irq_bank.sv]
// module: event enable and flag registers of one timer compare/capture channel, APB slave
//
// Contract
// - Enable bits 0,1 gate compare match A/B interrupts; writable; reset to zero.
// - Enable bits 2,3 gate capture A/B interrupts; writable; reset to zero.
// - Enable bits 4,5 gate capture A/B overwrite interrupts; writable; reset to zero.
// - Flag register bits 0..5 latch the six events, same layout, reset zero.
// - Writing one clears a flag, zero leaves it; flags stay latched otherwise.
//
// Our own choice: the APB register port.
module tcb_irq_bank (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire tcb_pkg::tcb_apb_req_s apb_req,
  output tcb_pkg::tcb_apb_rsp_s      apb_rsp,
  input  wire tcb_pkg::tcb_evt_s     events,
  input  wire logic [15:0]           cap_a_value,
  output logic [15:0]                cca_value,
  output logic                       chan_irq,
  output logic                       irq
);

  import tcb_pkg::*;

  // ----------------------------------------------------------------------
  // address decode helpers
  // ----------------------------------------------------------------------
  typedef enum logic [5:0] {
    TCB_SEL_NONE   = 6'b000001,
    TCB_SEL_CCA    = 6'b000010,
    TCB_SEL_ENABLE = 6'b000100,
    TCB_SEL_FLAGS  = 6'b001000,
    TCB_SEL_STATUS = 6'b010000,
    TCB_SEL_MASK   = 6'b100000
  } tcb_sel_e;

  // full-word compare, so an alias of a register answers as unmapped
  function automatic tcb_sel_e decode_addr(input logic [31:0] addr);
    tcb_sel_e sel;
    sel = TCB_SEL_NONE;
    if (addr == TCB_ADDR_CCA_DATA) begin
      sel = TCB_SEL_CCA;
    end else if (addr == TCB_ADDR_IRQ_ENABLE) begin
      sel = TCB_SEL_ENABLE;
    end else if (addr == TCB_ADDR_EVT_FLAGS) begin
      sel = TCB_SEL_FLAGS;
    end else if (addr == TCB_ADDR_IRQ_STATUS) begin
      sel = TCB_SEL_STATUS;
    end else if (addr == TCB_ADDR_IRQ_MASK) begin
      sel = TCB_SEL_MASK;
    end
    return sel;
  endfunction

  // merge a 16-bit register with write data under byte strobes
  function automatic logic [15:0] merge16(input logic [15:0] old_val,
                                          input logic [31:0] wdata,
                                          input logic [3:0]  strb);
    logic [15:0] res;
    res = old_val;
    if (strb[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (strb[1]) begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction

  // the six event bits live in byte lane 0 only
  function automatic logic [5:0] lane0_bits(input logic [31:0] wdata,
                                            input logic [3:0]  strb);
    return wdata[5:0] & {6{strb[0]}};
  endfunction

  function automatic logic [31:0] widen6(input logic [5:0] bits6);
    return {26'h000_0000, bits6};
  endfunction

  // one register hit by a completed access of the given direction
  function automatic logic reg_hit(input logic     done,
                                   input tcb_sel_e cur,
                                   input tcb_sel_e want);
    return done && (cur == want);
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [5:0]  irq_enable_reg;
  logic [5:0]  irq_mask_reg;
  logic [15:0] cca_reg;
  logic [5:0]  evt_flags;
  logic [5:0]  irq_status;
  logic [5:0]  evt_vec;
  logic [5:0]  flag_clr;
  logic [5:0]  status_clr;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        pslverr_next;
  logic        chan_irq_reg;
  logic        irq_reg;
  logic        setup_phase;
  logic        access_done;
  logic        wr_done;
  logic        rd_done;
  tcb_sel_e    sel;
  logic        enable_wr;
  logic        mask_wr;
  logic        flags_wr;
  logic        cca_wr;
  logic        status_rd;
  logic [5:0]  chan_pend;
  logic [5:0]  irq_pend;

  assign evt_vec     = events;
  assign sel         = decode_addr(apb_req.paddr);
  assign setup_phase = apb_req.psel & ~apb_req.penable;
  assign access_done = apb_req.psel & apb_req.penable & pready_reg;
  assign wr_done     = access_done & apb_req.pwrite;
  assign rd_done     = access_done & ~apb_req.pwrite;

  // ----------------------------------------------------------------------
  // register strobes of a completed access
  // ----------------------------------------------------------------------
  // lane 0 off leaves the six-bit registers alone
  assign enable_wr = reg_hit(wr_done, sel, TCB_SEL_ENABLE) & apb_req.pstrb[0];
  assign mask_wr   = reg_hit(wr_done, sel, TCB_SEL_MASK) & apb_req.pstrb[0];
  assign flags_wr  = reg_hit(wr_done, sel, TCB_SEL_FLAGS);
  assign cca_wr    = reg_hit(wr_done, sel, TCB_SEL_CCA);
  assign status_rd = reg_hit(rd_done, sel, TCB_SEL_STATUS);

  // ----------------------------------------------------------------------
  // apb handshake: one wait-free access phase after each setup
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= setup_phase;
    end
  end

  // read data and error are sampled in the setup cycle and held for the access
  always_comb begin
    prdata_next  = TCB_RST_DATA;
    pslverr_next = 1'b0;
    unique case (sel)
      TCB_SEL_CCA: begin
        prdata_next = {16'h0000, cca_reg};
      end
      TCB_SEL_ENABLE: begin
        prdata_next = widen6(irq_enable_reg);
      end
      TCB_SEL_FLAGS: begin
        prdata_next = widen6(evt_flags);
      end
      TCB_SEL_STATUS: begin
        prdata_next = widen6(irq_status);
      end
      TCB_SEL_MASK: begin
        prdata_next = widen6(irq_mask_reg);
      end
      TCB_SEL_NONE: begin
        // unmapped: error answer, any write is dropped
        pslverr_next = 1'b1;
      end
    endcase
  end

  // snapshot at setup: a status read clears exactly the bits it returned
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata_reg <= TCB_RST_DATA;
    end else if (setup_phase && !apb_req.pwrite) begin
      prdata_reg <= prdata_next;
    end else if (access_done) begin
      prdata_reg <= TCB_RST_DATA;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pslverr_reg <= 1'b0;
    end else if (setup_phase) begin
      pslverr_reg <= pslverr_next;
    end else if (access_done) begin
      pslverr_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // enable register
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_enable_reg <= TCB_RST_EVT;
    end else if (enable_wr) begin
      irq_enable_reg[TCB_BIT_CMP_A]     <= apb_req.pwdata[TCB_BIT_CMP_A];
      irq_enable_reg[TCB_BIT_CMP_B]     <= apb_req.pwdata[TCB_BIT_CMP_B];
      irq_enable_reg[TCB_BIT_CAP_A]     <= apb_req.pwdata[TCB_BIT_CAP_A];
      irq_enable_reg[TCB_BIT_CAP_B]     <= apb_req.pwdata[TCB_BIT_CAP_B];
      irq_enable_reg[TCB_BIT_CAP_A_OVR] <= apb_req.pwdata[TCB_BIT_CAP_A_OVR];
      irq_enable_reg[TCB_BIT_CAP_B_OVR] <= apb_req.pwdata[TCB_BIT_CAP_B_OVR];
    end
  end

  // ----------------------------------------------------------------------
  // mask register of the read-clear status
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_mask_reg <= TCB_RST_EVT;
    end else if (mask_wr) begin
      irq_mask_reg <= apb_req.pwdata[5:0];
    end
  end

  // ----------------------------------------------------------------------
  // compare/capture A data: capture strobe beats a software write
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cca_reg <= TCB_RST_CCA;
    end else if (events.cap_a) begin
      cca_reg <= cap_a_value;
    end else if (cca_wr) begin
      cca_reg <= merge16(cca_reg, apb_req.pwdata, apb_req.pstrb);
    end
  end

  // ----------------------------------------------------------------------
  // event flags: write one to clear, new event wins over the clear
  // ----------------------------------------------------------------------
  always_comb begin
    flag_clr = 6'h00;
    if (flags_wr) begin
      flag_clr = lane0_bits(apb_req.pwdata, apb_req.pstrb);
    end
  end

  tcb_sticky_bank #(
    .WIDTH (TCB_EVT_N)
  ) u_evt_flags (
    .core_clk (core_clk),
    .rst      (rst),
    .set_bits (evt_vec),
    .clr_bits (flag_clr),
    .flags    (evt_flags)
  );

  // ----------------------------------------------------------------------
  // interrupt status: cleared by reading it, only the bits that were read
  // ----------------------------------------------------------------------
  always_comb begin
    status_clr = 6'h00;
    // events landing after the setup snapshot stay pending
    if (status_rd) begin
      status_clr = prdata_reg[5:0];
    end
  end

  tcb_sticky_bank #(
    .WIDTH (TCB_EVT_N)
  ) u_irq_status (
    .core_clk (core_clk),
    .rst      (rst),
    .set_bits (evt_vec),
    .clr_bits (status_clr),
    .flags    (irq_status)
  );

  // ----------------------------------------------------------------------
  // pending sources
  // ----------------------------------------------------------------------
  assign chan_pend = evt_flags & irq_enable_reg;
  assign irq_pend  = irq_status & irq_mask_reg;

  // ----------------------------------------------------------------------
  // interrupt outputs: registered, so each pin lags its pending bits by one cycle
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      chan_irq_reg <= 1'b0;
    end else begin
      chan_irq_reg <= |chan_pend;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |irq_pend;
    end
  end

  // ----------------------------------------------------------------------
  // output drive
  // ----------------------------------------------------------------------
  assign apb_rsp.prdata  = prdata_reg;
  assign apb_rsp.pready  = pready_reg;
  assign apb_rsp.pslverr = pslverr_reg;
  assign cca_value       = cca_reg;
  assign chan_irq        = chan_irq_reg;
  assign irq             = irq_reg;

endmodule

// [logic/tcb_pkg.sv]
// package: register map, event layout and bus carrier types of the timer event interrupt bank
package tcb_pkg;

  // ----------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------
  localparam int unsigned TCB_DATA_W  = 32;
  localparam int unsigned TCB_ADDR_W  = 32;
  localparam int unsigned TCB_STRB_W  = 4;
  localparam int unsigned TCB_REG_W   = 16;
  localparam int unsigned TCB_EVT_N   = 6;

  // ----------------------------------------------------------------------
  // register indices and byte addresses (byte address = index * 4)
  // ----------------------------------------------------------------------
  localparam logic [15:0] TCB_IDX_CCA_DATA   = 16'h5408;
  localparam logic [15:0] TCB_IDX_IRQ_ENABLE = 16'h540a;
  localparam logic [15:0] TCB_IDX_EVT_FLAGS  = 16'h540c;
  localparam logic [15:0] TCB_IDX_IRQ_STATUS = 16'h540e;
  localparam logic [15:0] TCB_IDX_IRQ_MASK   = 16'h5410;

  localparam logic [31:0] TCB_ADDR_CCA_DATA   = {14'h0000, TCB_IDX_CCA_DATA, 2'b00};
  localparam logic [31:0] TCB_ADDR_IRQ_ENABLE = {14'h0000, TCB_IDX_IRQ_ENABLE, 2'b00};
  localparam logic [31:0] TCB_ADDR_EVT_FLAGS  = {14'h0000, TCB_IDX_EVT_FLAGS, 2'b00};
  localparam logic [31:0] TCB_ADDR_IRQ_STATUS = {14'h0000, TCB_IDX_IRQ_STATUS, 2'b00};
  localparam logic [31:0] TCB_ADDR_IRQ_MASK   = {14'h0000, TCB_IDX_IRQ_MASK, 2'b00};

  // ----------------------------------------------------------------------
  // field positions of enables, flags, status and mask (same layout)
  // ----------------------------------------------------------------------
  localparam int unsigned TCB_BIT_CMP_A     = 0;
  localparam int unsigned TCB_BIT_CMP_B     = 1;
  localparam int unsigned TCB_BIT_CAP_A     = 2;
  localparam int unsigned TCB_BIT_CAP_B     = 3;
  localparam int unsigned TCB_BIT_CAP_A_OVR = 4;
  localparam int unsigned TCB_BIT_CAP_B_OVR = 5;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [5:0]  TCB_RST_EVT  = 6'h00;
  localparam logic [15:0] TCB_RST_CCA  = 16'h0000;
  localparam logic [31:0] TCB_RST_DATA = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic cap_b_overrun;
    logic cap_a_overrun;
    logic cap_b;
    logic cap_a;
    logic cmp_b;
    logic cmp_a;
  } tcb_evt_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } tcb_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } tcb_apb_rsp_s;

endpackage

// [logic/tcb_sticky_bank.sv]
// module: bank of sticky flags where a set in the same cycle beats a clear
module tcb_sticky_bank #(
  parameter int unsigned WIDTH = 6
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] set_bits,
  input  wire logic [WIDTH-1:0] clr_bits,
  output logic      [WIDTH-1:0] flags
);

  logic [WIDTH-1:0] flags_reg;
  logic [WIDTH-1:0] flags_next;

  // ----------------------------------------------------------------------
  // flag update
  // ----------------------------------------------------------------------
  always_comb begin
    flags_next = (flags_reg & ~clr_bits) | set_bits;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;

endmodule

// [sim/tcb_irq_bank_chk.sv]
// checker: port-level assertions of the timer event interrupt bank
module tcb_irq_bank_chk (
  input wire logic                  core_clk,
  input wire logic                  rst,
  input wire tcb_pkg::tcb_apb_req_s apb_req,
  input wire tcb_pkg::tcb_apb_rsp_s apb_rsp,
  input wire tcb_pkg::tcb_evt_s     events,
  input wire logic [15:0]           cap_a_value,
  input wire logic [15:0]           cca_value,
  input wire logic                  chan_irq,
  input wire logic                  irq
);
  import tcb_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic acc_w;
  assign acc_w = apb_req.psel & apb_req.penable & apb_req.pwrite;
  // ----------------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------------
  setup_ready_a: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
    else $error("pready missing after setup");
  ready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready held too long");
  rsv_zero_a: assert property (apb_rsp.pready && !apb_req.pwrite && (apb_req.paddr == TCB_ADDR_IRQ_ENABLE
    || apb_req.paddr == TCB_ADDR_EVT_FLAGS) |-> apb_rsp.prdata[31:6] == 26'h0) else $error("reserved bits set");
  err_data_a: assert property (apb_rsp.pready && apb_rsp.pslverr |-> apb_rsp.prdata == 32'h0)
    else $error("error read returned data");
  // ----------------------------------------------------------------------
  // interrupt outputs and capture
  // ----------------------------------------------------------------------
  irq_cause_a: assert property ($rose(chan_irq) |-> $past(|events, 2)
    || $past(acc_w && apb_req.paddr == TCB_ADDR_IRQ_ENABLE, 2)) else $error("request rose without cause");
  flag_hold_a: assert property ($fell(chan_irq) |-> $past(acc_w && (apb_req.paddr == TCB_ADDR_IRQ_ENABLE
    || apb_req.paddr == TCB_ADDR_EVT_FLAGS), 2)) else $error("request fell without write");
  mask_irq_a: assert property ($rose(irq) |-> $past(|events, 2)
    || $past(acc_w && apb_req.paddr == TCB_ADDR_IRQ_MASK, 2)) else $error("irq rose without cause");
  cca_load_a: assert property (events.cap_a |=> cca_value == $past(cap_a_value))
    else $error("capture value not loaded");
  c_irq: cover property ($rose(chan_irq));
  c_err: cover property (apb_rsp.pready && apb_rsp.pslverr);
  c_cap: cover property (events.cap_a);
endmodule

bind tcb_irq_bank tcb_irq_bank_chk u_tcb_irq_bank_chk (.core_clk(core_clk), .rst(rst), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .events(events), .cap_a_value(cap_a_value), .cca_value(cca_value), .chan_irq(chan_irq),
  .irq(irq));

// [sim/tcb_irq_bank_tb_top.sv]
// testbench: register-level tests of the timer event interrupt bank
module tcb_irq_bank_tb_top
  import tcb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         core_clk;
  logic         rst;
  tcb_apb_req_s apb_req;
  tcb_apb_rsp_s apb_rsp;
  tcb_evt_s     events;
  logic [15:0]  cap_a_value;
  logic [15:0]  cca_value;
  logic         chan_irq;
  logic         irq;
  int           failures;
  int           samples_checked;
  logic [31:0]  rd;
  logic         er;
  logic [31:0]  b;

  tcb_irq_bank u_tcb_irq_bank (.core_clk(core_clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .events(events), .cap_a_value(cap_a_value), .cca_value(cca_value), .chan_irq(chan_irq), .irq(irq));

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    apb_req <= '{1'b1, 1'b0, w, a, d, 4'hf};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 16);
    if (n >= 16)
      failures++;
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    apb_req <= '0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rd, exp);
  endtask

  task automatic pulse(input logic [5:0] e);
    @(posedge core_clk);
    events <= e;
    @(posedge core_clk);
    events <= '0;
    repeat (3) @(posedge core_clk);
  endtask

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    failures++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    apb_req = '0;
    events = '0;
    cap_a_value = 16'h0000;
    failures = 0;
    samples_checked = 0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rdc("enable rst", TCB_ADDR_IRQ_ENABLE, 32'h0000_0000);
    rdc("flags rst", TCB_ADDR_EVT_FLAGS, 32'h0000_0000);
    wr(TCB_ADDR_IRQ_ENABLE, 32'hffff_ffff);
    rdc("enable all", TCB_ADDR_IRQ_ENABLE, 32'h0000_003f);
    wr(TCB_ADDR_IRQ_ENABLE, 32'h0000_0015);
    rdc("enable odd", TCB_ADDR_IRQ_ENABLE, 32'h0000_0015);
    for (int i = 0; i < 6; i++) begin
      b = 32'h0000_0001 << i;
      wr(TCB_ADDR_IRQ_ENABLE, 32'h0000_003f ^ b);
      pulse(b[5:0]);
      chk("irq gated", {31'h0, chan_irq}, 32'h0000_0000);
      wr(TCB_ADDR_IRQ_ENABLE, b);
      repeat (2) @(posedge core_clk);
      chk("irq on", {31'h0, chan_irq}, 32'h0000_0001);
      rdc("flag set", TCB_ADDR_EVT_FLAGS, b);
      wr(TCB_ADDR_EVT_FLAGS, 32'h0000_003f ^ b);
      rdc("flag kept", TCB_ADDR_EVT_FLAGS, b);
      wr(TCB_ADDR_EVT_FLAGS, b);
      repeat (2) @(posedge core_clk);
      chk("irq off", {31'h0, chan_irq}, 32'h0000_0000);
      rdc("flag clr", TCB_ADDR_EVT_FLAGS, 32'h0000_0000);
    end
    apb(1'b0, TCB_ADDR_IRQ_STATUS, 32'h0000_0000);
    wr(TCB_ADDR_IRQ_MASK, 32'h0000_0002);
    cap_a_value <= 16'ha5c3;
    pulse(6'h06);
    chk("irq mask", {31'h0, irq}, 32'h0000_0001);
    chk("cca port", {16'h0, cca_value}, 32'h0000_a5c3);
    rdc("cca reg", TCB_ADDR_CCA_DATA, 32'h0000_a5c3);
    rdc("status", TCB_ADDR_IRQ_STATUS, 32'h0000_0006);
    rdc("status clr", TCB_ADDR_IRQ_STATUS, 32'h0000_0000);
    rdc("flags both", TCB_ADDR_EVT_FLAGS, 32'h0000_0006);
    repeat (2) @(posedge core_clk);
    chk("irq clr", {31'h0, irq}, 32'h0000_0000);
    apb(1'b0, 32'h0000_0100, 32'h0000_0000);
    chk("unmapped err", {31'h0, er}, 32'h0000_0001);
    chk("unmapped data", rd, 32'h0000_0000);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rdc("enable rst2", TCB_ADDR_IRQ_ENABLE, 32'h0000_0000);
    rdc("flags rst2", TCB_ADDR_EVT_FLAGS, 32'h0000_0000);
    chk("irq rst2", {31'h0, chan_irq}, 32'h0000_0000);
    tally_and_finish();
  end
endmodule
